// ### rac_pkg.sv
// package: register map, field positions and reset values
package rac_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  // 16-bit register word addresses (byte address with bit 0 clear)
  localparam logic [8:0] OFS_ID = 9'h000;
  localparam logic [8:0] OFS_CTRL1 = 9'h002;
  localparam logic [8:0] OFS_CTRL2 = 9'h004;
  localparam logic [8:0] OFS_GIOCFG = 9'h00A;
  localparam logic [8:0] OFS_ISTAT = 9'h010;
  localparam logic [8:0] OFS_IEN = 9'h012;
  localparam logic [8:0] OFS_LIVE = 9'h014;
  localparam logic [8:0] OFS_LATCH = 9'h016;
  localparam logic [8:0] OFS_SIEN = 9'h018;
  localparam logic [8:0] OFS_GIORB = 9'h01C;
  localparam logic [8:0] OFS_CNT = 9'h01E;
  // functional block ranges that answer with ready
  localparam logic [8:0] GLB_LO = 9'h000;
  localparam logic [8:0] GLB_HI = 9'h01F;
  localparam logic [8:0] PORT_LO = 9'h040;
  localparam logic [8:0] PORT_HI = 9'h07F;
  localparam logic [8:0] LENC_LO = 9'h08C;
  localparam logic [8:0] LENC_HI = 9'h0DF;
  localparam logic [8:0] TRC_LO = 9'h0E8;
  localparam logic [8:0] TRC_HI = 9'h0FF;
  localparam logic [8:0] FRM_LO = 9'h118;
  localparam logic [8:0] FRM_HI = 9'h13F;
  localparam logic [8:0] TST_LO = 9'h180;
  localparam logic [8:0] TST_HI = 9'h19F;
  // writable bit masks
  localparam logic [15:0] CTRL1_MASK = 16'h40FF;
  localparam logic [15:0] CTRL2_MASK = 16'hFF0E;
  localparam logic [15:0] GIOCFG_MASK = 16'hFFFF;
  localparam logic [15:0] IEN_MASK = 16'h0011;
  localparam logic [15:0] LATCH_MASK = 16'h001F;
  // control-one field positions
  localparam int C1_SOFTRST = 1;
  localparam int C1_CLRSEL = 2;
  localparam int C1_UPDATE = 3;
  // latched / live bit positions
  localparam int ST_UPD = 0;
  localparam int ST_CLOL = 1;
  localparam int NUM_EV = 5;
  // reset values
  localparam logic [15:0] CTRL1_RST = 16'h0000;
  localparam logic [15:0] CTRL2_RST = 16'h0000;
  localparam logic [15:0] IEN_RST = 16'h0000;
  // arbitrary neutral identification value
  localparam logic [15:0] DEV_ID = 16'h0A5C;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
endpackage

// ### rac_pm_if.sv
// interface: counter update handshake between top and counter
`timescale 1ns/1ps
interface rac_pm_if;
  logic event_hit;
  logic update_req;
  logic clear;
  logic freeze;
  logic [15:0] held;
  logic update_busy_n;
  logic zero_n;
  modport ctrl (output event_hit, output update_req, output clear,
    output freeze, input held, input update_busy_n, input zero_n);
  modport cnt (input event_hit, input update_req, input clear,
    input freeze, output held, output update_busy_n, output zero_n);
endinterface

// ### rac_latch_bit.sv
// one latched or latched-on-change status bit
`timescale 1ns/1ps
module rac_latch_bit (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic event_i,
  input wire logic on_change_i,
  input wire logic enable_i,
  input wire logic clear_i,
  input wire logic force_clr_i,
  output logic latched_o
);
  logic prev_r;
  logic set_w;
  // RULE10 set on fresh onset only
  // RULE11 both edges when on-change
  assign set_w = enable_i &&
    ((event_i && !prev_r) || (on_change_i && !event_i && prev_r));
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
    end else if (ce_i) begin
      prev_r <= event_i;
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latched_o <= 1'b0;
    end else if (ce_i) begin
      if (force_clr_i) begin
        latched_o <= 1'b0;
      end else if (set_w) begin
        // set wins over clear
        latched_o <= 1'b1;
      end else if (clear_i) begin
        latched_o <= 1'b0;
      end
    end
  end
endmodule // rac_latch_bit

// ### rac_pm_counter.sv
// saturating event counter with snapshot register
`timescale 1ns/1ps
module rac_pm_counter (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  rac_pm_if.cnt pm
);
  logic [15:0] live_r;
  logic [15:0] held_r;
  typedef enum {PH_IDLE, PH_ZERO, PH_RAISE} rac_phase_type;
  rac_phase_type phase_r;
  logic req_d_r;
  logic zero_r;
  logic busy_r;
  logic start_w;
  // RULE7 rising edge starts update
  assign start_w = pm.update_req && !req_d_r;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_d_r <= 1'b0;
    end else if (ce_i) begin
      req_d_r <= pm.update_req;
    end
  end
  // RULE8 load, reset, zero low, raise
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_r <= PH_IDLE;
      busy_r <= 1'b0;
      zero_r <= 1'b1;
      held_r <= 16'h0000;
    end else if (ce_i) begin
      zero_r <= 1'b1;
      if (pm.clear) begin
        // RULE19 data path reset during or after a mode change clears
        held_r <= 16'h0000;
        phase_r <= PH_IDLE;
        busy_r <= 1'b0;
      end else begin
        case (phase_r)
          PH_IDLE: begin
            if (start_w) begin
              held_r <= live_r;
              busy_r <= 1'b1;
              phase_r <= PH_ZERO;
            end
          end
          PH_ZERO: begin
            zero_r <= 1'b0;
            phase_r <= PH_RAISE;
          end
          PH_RAISE: begin
            busy_r <= 1'b0;
            phase_r <= PH_IDLE;
          end
          default: begin
            phase_r <= PH_IDLE;
          end
        endcase
      end
    end
  end
  // RULE6 saturate, RULE9 count during load
  // RULE18 frozen counter keeps value
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      live_r <= 16'h0000;
    end else if (ce_i) begin
      if (pm.clear) begin
        live_r <= 16'h0000;
      end else if (phase_r == PH_IDLE && start_w) begin
        live_r <= (pm.event_hit && !pm.freeze) ? 16'h0001 : 16'h0000;
      end else if (pm.event_hit && !pm.freeze &&
                   live_r != rac_pkg::CNT_MAX) begin
        live_r <= live_r + 16'h0001;
      end
    end
  end
  assign pm.held = held_r;
  assign pm.update_busy_n = !busy_r;
  assign pm.zero_n = zero_r;
endmodule // rac_pm_counter

// ### rac_regs.sv
// global register bank with microprocessor port decode
`timescale 1ns/1ps
//**************************************************
// Operation
// RULE1: decode register space from nine address bits, banks in sequence
// RULE2: non-writable banks ignore writes and read zero
// RULE3: unassigned bits and unused registers discard writes, read zero
// RULE4: during data path reset, config writes stored but not applied
// RULE5: host re-issues rising-edge actions after data path reset
// RULE6: event counters saturate at maximum
// RULE7: update strobe rising edge starts update; status low meanwhile
// RULE8: load count, reset counter, zero indication low, raise status
// RULE9: no events lost during an update
// RULE10: latched bit sets on event, re-sets only after event returns
// RULE11: latched-on-change bit sets on event start and end
// RULE12: config bit selects clear-on-read or clear-on-write
// RULE13: clear-on-read clears sixteen bits, or accessed byte in 8-bit
// RULE14: clear-on-write clears only bit positions written with one
// RULE15: reserved config bits read and write, no effect
// RULE16: reserved status reads zero; reserved latched not set by events
// RULE17: reserved interrupt enable still raises interrupt if latched
// RULE18: reserved counter holds value, no increments, updates still work
// RULE19: data path reset clears latched bits and counters; code clears only during or after a mode change
// RULE20: host clears latched bits by access, counters by two updates
// RULE21: ready inactive for unused space outside blocks, else active
// RULE22: 8-bit mode odd byte is upper half, even is lower
//**************************************************
module rac_regs (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic datapath_reset_n_i,
  input wire logic [8:0] adr_i,
  input wire logic [15:0] wdata_i,
  input wire logic cs_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic bus8_i,
  input wire logic mode_change_i,
  input wire logic [4:0] event_i,
  input wire logic [4:0] event_valid_i,
  input wire logic count_event_i,
  input wire logic count_valid_i,
  input wire logic port_irq_i,
  input wire logic [7:0] gpio_i,
  output logic [15:0] rdata_o,
  output logic ready_o,
  output logic global_update_status_o,
  output logic zero_count_n_o,
  output logic irq_o,
  output logic datapath_soft_reset_o,
  output logic [15:0] active_ctrl1_o,
  output logic [15:0] active_ctrl2_o,
  output logic [15:0] active_giocfg_o
);
  //**************************************************
  // access decode
  //**************************************************
  logic [8:0] word_w;
  logic in_block_w;
  logic access_w;
  logic lo_w;
  logic hi_w;
  logic [15:0] lane_w;
  logic [15:0] wval_w;
  logic dp_rst_w;
  // RULE1 nine-bit address, word index
  assign word_w = {adr_i[8:1], 1'b0};
  // RULE21 ready only inside functional blocks
  always_comb begin
    in_block_w = 1'b0;
    if (adr_i <= rac_pkg::GLB_HI) in_block_w = 1'b1;
    if (adr_i >= rac_pkg::PORT_LO && adr_i <= rac_pkg::PORT_HI)
      in_block_w = 1'b1;
    if (adr_i >= rac_pkg::LENC_LO && adr_i <= rac_pkg::LENC_HI)
      in_block_w = 1'b1;
    if (adr_i >= rac_pkg::TRC_LO && adr_i <= rac_pkg::TRC_HI)
      in_block_w = 1'b1;
    if (adr_i >= rac_pkg::FRM_LO && adr_i <= rac_pkg::FRM_HI)
      in_block_w = 1'b1;
    if (adr_i >= rac_pkg::TST_LO && adr_i <= rac_pkg::TST_HI)
      in_block_w = 1'b1;
  end
  assign access_w = cs_i && (wr_i || rd_i);
  assign ready_o = access_w && in_block_w;
  // RULE22 odd byte is upper half in 8-bit mode
  assign lo_w = !bus8_i || !adr_i[0];
  assign hi_w = !bus8_i || adr_i[0];
  assign lane_w = {{8{hi_w}}, {8{lo_w}}};
  assign wval_w = bus8_i ? {wdata_i[7:0], wdata_i[7:0]} : wdata_i;
  assign dp_rst_w = !datapath_reset_n_i;
  //**************************************************
  // configuration registers
  //**************************************************
  logic [15:0] ctrl1_r;
  logic [15:0] ctrl2_r;
  logic [15:0] giocfg_r;
  logic [15:0] ien_r;
  logic wr_glb_w;
  assign wr_glb_w = cs_i && wr_i && (adr_i <= rac_pkg::GLB_HI);
  // RULE2 RULE3 RULE15 masked writes, unused dropped
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl1_r <= rac_pkg::CTRL1_RST;
      ctrl2_r <= rac_pkg::CTRL2_RST;
      giocfg_r <= 16'h0000;
      ien_r <= rac_pkg::IEN_RST;
    end else if (ce_i && wr_glb_w) begin
      case (word_w)
        rac_pkg::OFS_CTRL1: ctrl1_r <= (ctrl1_r & ~lane_w) |
          (wval_w & lane_w & rac_pkg::CTRL1_MASK);
        rac_pkg::OFS_CTRL2: ctrl2_r <= (ctrl2_r & ~lane_w) |
          (wval_w & lane_w & rac_pkg::CTRL2_MASK);
        rac_pkg::OFS_GIOCFG: giocfg_r <= (giocfg_r & ~lane_w) |
          (wval_w & lane_w & rac_pkg::GIOCFG_MASK);
        rac_pkg::OFS_IEN: ien_r <= (ien_r & ~lane_w) |
          (wval_w & lane_w & rac_pkg::IEN_MASK);
        default: begin
        end
      endcase
    end
  end
  // RULE4 stored values applied only outside data path reset
  logic [15:0] act1_r;
  logic [15:0] act2_r;
  logic [15:0] actg_r;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act1_r <= rac_pkg::CTRL1_RST;
      act2_r <= rac_pkg::CTRL2_RST;
      actg_r <= 16'h0000;
    end else if (ce_i && !dp_rst_w) begin
      act1_r <= ctrl1_r;
      act2_r <= ctrl2_r;
      actg_r <= giocfg_r;
    end
  end
  assign active_ctrl1_o = act1_r;
  assign active_ctrl2_o = act2_r;
  assign active_giocfg_o = actg_r;
  assign datapath_soft_reset_o = act1_r[rac_pkg::C1_SOFTRST];
  //**************************************************
  // mode-change tracking for data path reset clearing
  //**************************************************
  logic mc_pend_r;
  logic dp_clear_w;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mc_pend_r <= 1'b0;
    end else if (ce_i) begin
      if (mode_change_i) mc_pend_r <= 1'b1;
      else if (dp_rst_w) mc_pend_r <= 1'b0;
    end
  end
  // RULE19 clear during or after a mode change
  assign dp_clear_w = dp_rst_w && (mc_pend_r || mode_change_i);
  //**************************************************
  // performance counter
  //**************************************************
  rac_pm_if pm ();
  assign pm.event_hit = count_event_i;
  // RULE18 reserved counter frozen
  assign pm.freeze = !count_valid_i;
  assign pm.update_req = act1_r[rac_pkg::C1_UPDATE];
  assign pm.clear = dp_clear_w;
  rac_pm_counter u_cnt (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pm(pm)
  );
  assign global_update_status_o = pm.update_busy_n;
  assign zero_count_n_o = pm.zero_n;
  //**************************************************
  // latched status bits
  //**************************************************
  logic rd_latch_w;
  logic wr_latch_w;
  logic [15:0] clr_w;
  logic [4:0] latch_w;
  logic [4:0] live_w;
  assign rd_latch_w = ce_i && cs_i && rd_i && word_w == rac_pkg::OFS_LATCH;
  assign wr_latch_w = ce_i && cs_i && wr_i && word_w == rac_pkg::OFS_LATCH;
  // RULE12 clear mode select
  // RULE13 read clears accessed lanes
  // RULE14 write-one clears position
  always_comb begin
    clr_w = 16'h0000;
    if (act1_r[rac_pkg::C1_CLRSEL]) begin
      if (wr_latch_w) clr_w = wval_w & lane_w;
    end else if (rd_latch_w) begin
      clr_w = lane_w;
    end
  end
  // RULE16 reserved bits: status zero, no event sets
  assign live_w = event_i & event_valid_i;
  // update-done pulse; the idle-high level would latch at reset exit
  logic ups_d_r;
  logic upd_done_w;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ups_d_r <= 1'b1;
    end else if (ce_i) begin
      ups_d_r <= pm.update_busy_n;
    end
  end
  assign upd_done_w = pm.update_busy_n && !ups_d_r;
  genvar g;
  generate
    for (g = 0; g < rac_pkg::NUM_EV; g++) begin : g_lat
      rac_latch_bit u_lat (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .event_i(g == rac_pkg::ST_UPD ? upd_done_w : live_w[g]),
        .on_change_i(g == rac_pkg::ST_CLOL),
        .enable_i(g == rac_pkg::ST_UPD ? 1'b1 : event_valid_i[g]),
        .clear_i(clr_w[g]),
        .force_clr_i(dp_clear_w),
        .latched_o(latch_w[g])
      );
    end
  endgenerate
  //**************************************************
  // interrupt and read mux
  //**************************************************
  logic [15:0] sien_w;
  logic glb_irq_w;
  // RULE17 reserved enables still gate latched bits
  assign sien_w = {13'h0000, ien_r[2:0]};
  assign glb_irq_w = |(latch_w[2:0] & sien_w[2:0]);
  assign irq_o = (glb_irq_w && ien_r[0]) || (port_irq_i && ien_r[4]);
  logic [15:0] rword_w;
  always_comb begin
    rword_w = 16'h0000;
    // RULE2 RULE3 unlisted addresses read zero
    if (adr_i <= rac_pkg::GLB_HI) begin
      case (word_w)
        rac_pkg::OFS_ID: rword_w = rac_pkg::DEV_ID;
        rac_pkg::OFS_CTRL1: rword_w = ctrl1_r;
        rac_pkg::OFS_CTRL2: rword_w = ctrl2_r;
        rac_pkg::OFS_GIOCFG: rword_w = giocfg_r;
        rac_pkg::OFS_ISTAT: rword_w = {11'h000, port_irq_i, 3'h0,
          glb_irq_w};
        rac_pkg::OFS_IEN: rword_w = ien_r;
        rac_pkg::OFS_LIVE: rword_w = {14'h0000, live_w[rac_pkg::ST_CLOL],
          pm.update_busy_n};
        rac_pkg::OFS_LATCH: rword_w = {11'h000, latch_w};
        rac_pkg::OFS_SIEN: rword_w = sien_w;
        rac_pkg::OFS_GIORB: rword_w = {8'h00, gpio_i};
        rac_pkg::OFS_CNT: rword_w = pm.held;
        default: rword_w = 16'h0000;
      endcase
    end
  end
  // data output registered; 8-bit mode returns lane in low byte
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (ce_i && cs_i && rd_i) begin
      rdata_o <= (bus8_i && adr_i[0]) ? {8'h00, rword_w[15:8]} :
        (bus8_i ? {8'h00, rword_w[7:0]} : rword_w);
    end
  end
endmodule // rac_regs

// ### rac_regs_props.sv
// checker: port-level properties of the global register bank
`timescale 1ns/1ps
module rac_regs_props (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic datapath_reset_n_i,
  input wire logic [8:0] adr_i,
  input wire logic cs_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic bus8_i,
  input wire logic [15:0] rdata_o,
  input wire logic ready_o,
  input wire logic global_update_status_o,
  input wire logic zero_count_n_o,
  input wire logic [15:0] active_ctrl1_o,
  input wire logic [15:0] active_ctrl2_o
);
  //********
  // properties
  //********
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic acc;
  logic rdq;
  assign acc = ce_i & cs_i & (wr_i | rd_i);
  assign rdq = ce_i & cs_i & rd_i;

  chk_ready_gap: assert property (
    acc && adr_i[8:5] == 4'h1 |-> !ready_o)
    else $error("ready raised in unused space");
  chk_ready_global: assert property (
    acc && adr_i[8:5] == 4'h0 |-> ready_o)
    else $error("no ready in global bank");
  chk_unused_zero: assert property (
    rdq && adr_i[8:1] == 8'h03 |=> rdata_o == 16'h0000)
    else $error("unused register read not zero");
  chk_bank_zero: assert property (
    rdq && adr_i[8:6] == 3'h1 |=> rdata_o == 16'h0000)
    else $error("port bank read not zero");
  chk_id_word: assert property (
    rdq && !bus8_i && adr_i == 9'h000 |=> rdata_o == rac_pkg::DEV_ID)
    else $error("identification word wrong");
  chk_id_upper: assert property (
    rdq && bus8_i && adr_i == 9'h001 |=> rdata_o[7:0] == 8'h0A)
    else $error("odd byte is not the upper half");
  chk_zero_pulse: assert property (
    $fell(zero_count_n_o) |->
      !global_update_status_o ##1 (zero_count_n_o && global_update_status_o))
    else $error("zero pulse or status order wrong");
  chk_update_start: assert property (
    $rose(active_ctrl1_o[3]) |-> ##[0:2] !global_update_status_o)
    else $error("update did not drop status");
  chk_dp_freeze: assert property (
    !datapath_reset_n_i [*3] |-> $stable(active_ctrl2_o))
    else $error("config applied during data path reset");
endmodule // rac_regs_props

bind rac_regs rac_regs_props u_props (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .datapath_reset_n_i(datapath_reset_n_i), .adr_i(adr_i), .cs_i(cs_i),
  .wr_i(wr_i), .rd_i(rd_i), .bus8_i(bus8_i), .rdata_o(rdata_o),
  .ready_o(ready_o), .global_update_status_o(global_update_status_o),
  .zero_count_n_o(zero_count_n_o), .active_ctrl1_o(active_ctrl1_o),
  .active_ctrl2_o(active_ctrl2_o)
);

// ### rac_host_model.sv
// host model: microprocessor master of the register port
`timescale 1ns/1ps
module rac_host_model (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  input wire logic ready_i,
  output logic [8:0] adr_o,
  output logic [15:0] wdata_o,
  output logic cs_o,
  output logic wr_o,
  output logic rd_o
);
  //********
  // bus access
  //********
  initial begin
    adr_o = 9'h000;
    wdata_o = 16'h0000;
    cs_o = 1'b0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one-cycle strobe; released lines show the inverse, not stale data
  task automatic access(input logic w, input logic [8:0] a,
      input logic [15:0] d, output logic [15:0] q, output logic r);
    @(posedge clk_i);
    #1;
    adr_o = a;
    wdata_o = d;
    cs_o = 1'b1;
    wr_o = w;
    rd_o = !w;
    @(posedge clk_i);
    r = ready_i;
    #1;
    q = rdata_i;
    cs_o = 1'b0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    adr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule // rac_host_model

// ### rac_regs_tb.sv
// testbench: register bank against a behavioural model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_fail++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module rac_regs_tb;
  //********
  // bench
  //********
  logic core_clk_i, rst_i, dp_n, bus8, mchg, cev, cval, pirq, rdy;
  logic cs, wr_s, rd_s, ready, ups, zn, srst;
  logic [4:0] ev, evv;
  logic [7:0] gpio;
  logic [8:0] adr;
  logic [15:0] wdata, rdata, a1, a2, ag, q, h;
  logic [15:0] mreg [0:15];
  logic [8:0] tab [0:7];
  // bit 9 holds the expected ready
  logic [9:0] bt [0:6];
  int n_fail, total_checks, cyc, n, k;

  rac_regs u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .datapath_reset_n_i(dp_n), .adr_i(adr), .wdata_i(wdata), .cs_i(cs),
    .wr_i(wr_s), .rd_i(rd_s), .bus8_i(bus8), .mode_change_i(mchg),
    .event_i(ev), .event_valid_i(evv), .count_event_i(cev),
    .count_valid_i(cval), .port_irq_i(pirq), .gpio_i(gpio),
    .rdata_o(rdata), .ready_o(ready), .global_update_status_o(ups),
    .zero_count_n_o(zn), .irq_o(), .datapath_soft_reset_o(srst),
    .active_ctrl1_o(a1), .active_ctrl2_o(a2), .active_giocfg_o(ag));
  rac_host_model u_host (.clk_i(core_clk_i), .rdata_i(rdata),
    .ready_i(ready), .adr_o(adr), .wdata_o(wdata), .cs_o(cs),
    .wr_o(wr_s), .rd_o(rd_s));

  function automatic logic [15:0] msk(input logic [8:0] a);
    case (a)
      rac_pkg::OFS_CTRL1: msk = rac_pkg::CTRL1_MASK;
      rac_pkg::OFS_CTRL2: msk = rac_pkg::CTRL2_MASK;
      rac_pkg::OFS_GIOCFG: msk = rac_pkg::GIOCFG_MASK;
      rac_pkg::OFS_IEN: msk = rac_pkg::IEN_MASK;
      default: msk = 16'h0000;
    endcase
  endfunction
  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    u_host.access(1'b1, a, d, q, rdy);
    mreg[a[4:1]] = (mreg[a[4:1]] & ~msk(a)) | (d & msk(a));
  endtask
  task automatic rd(input logic [8:0] a);
    u_host.access(1'b0, a, 16'h0000, q, rdy);
  endtask
  // bit 0 follows update activity, so it is left out
  task automatic rdl(input logic [15:0] e);
    rd(rac_pkg::OFS_LATCH);
    `CHK("latched", e, q & 16'hFFFE)
  endtask
  task automatic evp(input logic [4:0] m);
    ev = m;
    repeat (2) tick();
    ev = 5'h00;
    repeat (2) tick();
  endtask
  task automatic pulse(input int c);
    repeat (c) begin
      cev = 1'b1;
      tick();
      cev = 1'b0;
      tick();
    end
  endtask
  task automatic upd();
    wr(rac_pkg::OFS_CTRL1, mreg[1] & 16'hFFF7);
    wr(rac_pkg::OFS_CTRL1, mreg[1] | 16'h0008);
    n = 0;
    while (ups !== 1'b0 && n < 8) begin
      tick();
      n++;
    end
    `CHK("update busy", 1'b1, n < 8)
    while (ups !== 1'b1 && n < 16) begin
      tick();
      n++;
    end
    `CHK("update done", 1'b1, ups)
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(32'h3635839E));
    {rst_i, dp_n, bus8, mchg, cev, cval, ev, evv} = 16'hC41F;
    pirq = 1'($urandom);
    gpio = 8'($urandom);
    foreach (mreg[i]) mreg[i] = 16'h0000;
    mreg[0] = rac_pkg::DEV_ID;
    tab = '{rac_pkg::OFS_CTRL1, rac_pkg::OFS_CTRL2, rac_pkg::OFS_GIOCFG,
      rac_pkg::OFS_IEN, rac_pkg::OFS_ID, 9'h006, 9'h00C, 9'h01A};
    bt = '{10'h020, 10'h240, 10'h080, 10'h0E0, 10'h318, 10'h1A0, 10'h380};
    repeat (5) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    foreach (tab[i]) begin
      rd(tab[i]);
      `CHK("reset value", mreg[tab[i][4:1]], q)
    end
    repeat (16) begin
      k = $urandom_range(7);
      h = 16'($urandom);
      if (k == 0) h[3:1] = 3'b000;
      wr(tab[k], h);
      rd(tab[k]);
      `CHK("readback", mreg[tab[k][4:1]], q)
    end
    `CHK("applied", mreg[2], a2)
    `CHK("applied one", mreg[1], a1)
    `CHK("applied gio", mreg[5], ag)
    `CHK("soft reset", mreg[1][1], srst)
    foreach (bt[i]) begin
      wr(bt[i][8:0], 16'hFFFF);
      `CHK("ready", bt[i][9], rdy)
      rd(bt[i][8:0]);
      `CHK("bank read", 16'h0000, q)
    end
    rd(rac_pkg::OFS_GIORB);
    `CHK("gpio", {8'h00, gpio}, q)
    bus8 = 1'b1;
    rd(9'h000);
    `CHK("low byte", rac_pkg::DEV_ID[7:0], q[7:0])
    rd(9'h001);
    `CHK("high byte", rac_pkg::DEV_ID[15:8], q[7:0])
    u_host.access(1'b1, 9'h003, 16'h00FF, q, rdy);
    bus8 = 1'b0;
    mreg[1][15:8] = rac_pkg::CTRL1_MASK[15:8];
    rd(rac_pkg::OFS_CTRL1);
    `CHK("byte lane", mreg[1], q)
    n = $urandom_range(20, 3);
    k = n;
    pulse(n);
    upd();
    rd(rac_pkg::OFS_CNT);
    `CHK("count", k[15:0], q)
    k = $urandom_range(12, 4);
    fork
      upd();
      pulse(k);
    join
    rd(rac_pkg::OFS_CNT);
    h = q;
    upd();
    rd(rac_pkg::OFS_CNT);
    `CHK("split count", k[15:0], h + q)
    upd();
    rd(rac_pkg::OFS_CNT);
    `CHK("second update", 16'h0000, q)
    cval = 1'b0;
    pulse(3);
    upd();
    rd(rac_pkg::OFS_CNT);
    `CHK("reserved count", 16'h0000, q)
    cval = 1'b1;
    wr(rac_pkg::OFS_CTRL1, 16'h0000);
    rd(rac_pkg::OFS_LATCH);
    ev = 5'h06;
    repeat (2) tick();
    rdl(16'h0006);
    rdl(16'h0000);
    ev = 5'h00;
    repeat (2) tick();
    rdl(16'h0002);
    wr(rac_pkg::OFS_CTRL1, 16'h0004);
    evp(5'h06);
    rdl(16'h0006);
    wr(rac_pkg::OFS_LATCH, 16'h0004);
    rdl(16'h0002);
    wr(rac_pkg::OFS_LATCH, 16'h0002);
    evv = 5'h1D;
    evp(5'h02);
    rdl(16'h0000);
    evv = 5'h1F;
    evp(5'h04);
    mchg = 1'b1;
    tick();
    {mchg, dp_n} = 2'b00;
    tick();
    h = a2;
    wr(rac_pkg::OFS_CTRL2, ~mreg[2]);
    rd(rac_pkg::OFS_CTRL2);
    `CHK("ctrl in reset", mreg[2], q)
    `CHK("frozen config", h, a2)
    dp_n = 1'b1;
    repeat (2) tick();
    rdl(16'h0000);
    wr(rac_pkg::OFS_CTRL2, mreg[2]);
    repeat (2) tick();
    `CHK("reapplied", mreg[2], a2)
    print_verdict();
  end
endmodule // rac_regs_tb
